// File: rtl/adc_regs_pkg.sv
package adc_regs_pkg;

  // ----------------------------------------------------------------
  // register index map (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int NREG = 64;
  typedef logic [5:0] idx_t;

  localparam idx_t IDX_CTL_A = 6'h00;
  localparam idx_t IDX_REF = 6'h01;
  localparam idx_t IDX_AVG = 6'h02;
  localparam idx_t IDX_SAMP = 6'h03;
  localparam idx_t IDX_CTL_B = 6'h04;
  localparam idx_t IDX_WIN = 6'h08;
  localparam idx_t IDX_TRIG = 6'h0C;
  localparam idx_t IDX_INPUT = 6'h10;
  localparam idx_t IDX_EVT = 6'h14;
  localparam idx_t IDX_IENCLR = 6'h16;
  localparam idx_t IDX_IENSET = 6'h17;
  localparam idx_t IDX_FLAG = 6'h18;
  localparam idx_t IDX_STATUS = 6'h19;
  localparam idx_t IDX_RESULT = 6'h1A;
  localparam idx_t IDX_WLO = 6'h1C;
  localparam idx_t IDX_WHI = 6'h20;
  localparam idx_t IDX_GAIN = 6'h24;
  localparam idx_t IDX_OFFS = 6'h26;
  localparam idx_t IDX_CAL = 6'h28;
  localparam idx_t IDX_DBG = 6'h2A;

  // ----------------------------------------------------------------
  // implemented bits per register, reset value
  // ----------------------------------------------------------------
  localparam logic [31:0] MSK_CTL_A = 32'h0000_0007;
  localparam logic [31:0] MSK_REF = 32'h0000_008F;
  localparam logic [31:0] MSK_AVG = 32'h0000_007F;
  localparam logic [31:0] MSK_SAMP = 32'h0000_003F;
  localparam logic [31:0] MSK_CTL_B = 32'h0000_0737;
  localparam logic [31:0] MSK_WIN = 32'h0000_0007;
  localparam logic [31:0] MSK_TRIG = 32'h0000_0003;
  localparam logic [31:0] MSK_INPUT = 32'h0FFF_1F1F;
  localparam logic [31:0] MSK_EVT = 32'h0000_0033;
  localparam logic [31:0] MSK_IRQ = 32'h0000_000F;
  localparam logic [31:0] MSK_STATUS = 32'h0000_0080;
  localparam logic [31:0] MSK_HALF = 32'h0000_FFFF;
  localparam logic [31:0] MSK_CORR = 32'h0000_0FFF;
  localparam logic [31:0] MSK_CAL = 32'h0000_07FF;
  localparam logic [31:0] MSK_DBG = 32'h0000_0001;
  localparam logic [31:0] RST_VAL = 32'h0000_0000;
  localparam logic [31:0] CA_SRST_SET = 32'h0000_0001;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CA_SRST = 0;
  localparam int CA_EN = 1;
  localparam int CA_RUNSTBY = 2;
  localparam int SW_FLUSH = 0;
  localparam int SW_START = 1;
  localparam int FL_RESRDY = 0;
  localparam int FL_OVERRUN = 1;
  localparam int FL_WINMON = 2;
  localparam int FL_SYNC = 3;

  // ----------------------------------------------------------------
  // timing and bus answers
  // ----------------------------------------------------------------
  localparam logic [2:0] SYNC_CYCLES = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // settings applied in the converter domain
  typedef struct packed {
    logic enable;
    logic [10:0] ctrl_b;
    logic [2:0] win_mode;
    logic [27:0] input_sel;
    logic [15:0] win_lo;
    logic [15:0] win_hi;
  } conv_cfg_t;

  // events reported by the converter core
  typedef struct packed {
    logic result_ready;
    logic overrun;
    logic window_match;
    logic [15:0] result;
  } conv_evt_t;

endpackage

// File: rtl/adc_register_interface.sv
// Behaviour
// - byte, halfword and word accesses all accepted
// - each byte or half writable by strobes
// - guarded registers ignore writes under access guard
// - enable-protected registers writable only while disabled
// - synchronized accesses complete through the sync path
// - run_in_standby bit two keeps converter running
// - enable reads back at once, applies later
// - synchronized write sets busy until completion
// - soft reset clears all but debug, disables
// - synced access while busy stalls, then completes
// - flags clear by writing one, zero ignored
`timescale 1ns/1ps
`default_nettype none

module adc_register_interface (
  // clock, reset, clock enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write address and data
  input wire logic [adc_regs_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output var logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output var logic wready,
  // axi4-lite write response
  output var logic [1:0] bresp,
  output var logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [adc_regs_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output var logic arready,
  output var logic [31:0] rdata,
  output var logic [1:0] rresp,
  output var logic rvalid,
  input wire logic rready,
  // system controls
  input wire logic peripheral_access_guard,
  input wire logic standby_sleep,
  // converter core
  input wire adc_regs_pkg::conv_evt_t conv_evt,
  output var adc_regs_pkg::conv_cfg_t conv_cfg,
  output var logic conv_active,
  output var logic conv_start,
  output var logic conv_flush,
  // interrupt
  output var logic irq
);
  import adc_regs_pkg::*;

  // ----------------------------------------------------------------
  // decode functions
  // ----------------------------------------------------------------
  // implemented bits of a register, zero when unmapped
  function automatic logic [31:0] mask_of(input idx_t i);
    logic [31:0] m;
    m = 32'h0000_0000;
    case (i)
      IDX_CTL_A: m = MSK_CTL_A;
      IDX_REF: m = MSK_REF;
      IDX_AVG: m = MSK_AVG;
      IDX_SAMP: m = MSK_SAMP;
      IDX_CTL_B: m = MSK_CTL_B;
      IDX_WIN: m = MSK_WIN;
      IDX_TRIG: m = MSK_TRIG;
      IDX_INPUT: m = MSK_INPUT;
      IDX_EVT: m = MSK_EVT;
      IDX_IENCLR, IDX_IENSET, IDX_FLAG: m = MSK_IRQ;
      IDX_STATUS: m = MSK_STATUS;
      IDX_RESULT, IDX_WLO, IDX_WHI: m = MSK_HALF;
      IDX_GAIN, IDX_OFFS: m = MSK_CORR;
      IDX_CAL: m = MSK_CAL;
      IDX_DBG: m = MSK_DBG;
      default: m = 32'h0000_0000;
    endcase
    return m;
  endfunction

  // registers whose writes cross to the converter
  function automatic logic is_wsync(input idx_t i);
    return i == IDX_CTL_A || i == IDX_CTL_B || i == IDX_TRIG ||
           i == IDX_WIN || i == IDX_INPUT || i == IDX_WLO ||
           i == IDX_WHI;
  endfunction

  // registers whose reads cross from the converter
  function automatic logic is_rsync(input idx_t i);
    return i == IDX_TRIG || i == IDX_INPUT;
  endfunction

  // registers that ignore writes under the access guard
  function automatic logic is_wp(input idx_t i);
    return mask_of(i) != 32'h0000_0000 && i != IDX_IENCLR &&
           i != IDX_IENSET && i != IDX_FLAG && i != IDX_STATUS &&
           i != IDX_RESULT;
  endfunction

  // registers writable only while the converter is off
  function automatic logic is_ep(input idx_t i);
    return i == IDX_REF || i == IDX_AVG || i == IDX_SAMP ||
           i == IDX_CTL_B;
  endfunction

  // plain storage registers written from the bus
  function automatic logic is_plain(input idx_t i);
    return is_wp(i) && i != IDX_CTL_A;
  endfunction

  // byte-lane merge of write data
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[b*8 +: 8] = data[b*8 +: 8];
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0] regs_reg [0:NREG-1];
  logic [3:0] flags_reg;
  logic [3:0] imask_reg;
  logic [15:0] result_reg;
  logic [2:0] sync_cnt_reg;
  conv_cfg_t conv_cfg_reg;
  logic conv_active_reg, conv_start_reg, conv_flush_reg, irq_reg;
  logic awready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic rd_wait_reg;
  idx_t rd_idx_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  idx_t wr_idx, ar_idx, sel_idx;
  logic wr_fire, rd_acc, busy, sync_start, sync_done, srst_pend;
  logic srst_apply, conv_on, wp_block, ep_block, wr_ok, srst_wr;
  logic wstall, rstall, wr_mapped;
  logic [1:0] wr_resp;
  logic [31:0] wr_merged, wr_val, rd_word;
  logic [3:0] flag_clr, flag_set, flags_next, ien_clr, ien_set;
  conv_cfg_t cfg_next;

  // address indexes and handshakes
  assign wr_idx = awaddr[7:2];
  assign ar_idx = araddr[7:2];
  assign sel_idx = rd_wait_reg ? rd_idx_reg : ar_idx;
  assign wr_fire = awready_reg && awvalid && wvalid;
  assign rd_acc = arready_reg && arvalid;
  assign wr_mapped = mask_of(wr_idx) != 32'h0000_0000;

  // protection and synchronization decode
  assign busy = sync_cnt_reg != 3'h0;
  assign sync_done = sync_cnt_reg == 3'h1;
  assign srst_pend = regs_reg[IDX_CTL_A][CA_SRST];
  assign srst_apply = sync_done && srst_pend;
  assign conv_on = regs_reg[IDX_CTL_A][CA_EN] || conv_cfg_reg.enable;
  assign wp_block = peripheral_access_guard && is_wp(wr_idx);
  assign ep_block = conv_on && is_ep(wr_idx);
  assign wr_ok = wr_fire && wr_mapped && !wp_block && !ep_block;
  assign srst_wr = wr_ok && wr_idx == IDX_CTL_A && wstrb[0] &&
                   wdata[CA_SRST];
  assign sync_start = (wr_ok && is_wsync(wr_idx)) ||
                      (rd_acc && is_rsync(ar_idx));
  assign wstall = is_wsync(wr_idx) && (busy || sync_start);
  assign rstall = is_rsync(ar_idx) && (busy || sync_start);
  assign wr_resp = (!wr_mapped || wp_block) ? RESP_SLVERR : RESP_OKAY;

  // write value with strobes; soft reset discards the other bits
  assign wr_merged = merge(regs_reg[wr_idx], wdata, wstrb) &
                     mask_of(wr_idx);
  assign wr_val = srst_wr ? (regs_reg[IDX_CTL_A] | CA_SRST_SET) :
                  wr_merged;

  // interrupt flag and mask updates
  assign flag_clr = (wr_ok && wr_idx == IDX_FLAG && wstrb[0]) ?
                    wdata[3:0] : 4'h0;
  assign flag_set = {sync_done, conv_evt.window_match,
                     conv_evt.overrun, conv_evt.result_ready};
  assign flags_next = (flags_reg & ~flag_clr) | flag_set;
  assign ien_clr = (wr_ok && wr_idx == IDX_IENCLR && wstrb[0]) ?
                   wdata[3:0] : 4'h0;
  assign ien_set = (wr_ok && wr_idx == IDX_IENSET && wstrb[0]) ?
                   wdata[3:0] : 4'h0;

  // read data selection
  assign rd_word =
    (sel_idx == IDX_FLAG) ? {28'h0000000, flags_reg} :
    (sel_idx == IDX_IENCLR || sel_idx == IDX_IENSET) ?
      {28'h0000000, imask_reg} :
    (sel_idx == IDX_STATUS) ? {24'h000000, busy, 7'h00} :
    (sel_idx == IDX_RESULT) ? {16'h0000, result_reg} :
    (sel_idx == IDX_INPUT) ? {4'h0, conv_cfg_reg.input_sel} :
    regs_reg[sel_idx] & mask_of(sel_idx);

  // settings handed to the converter at sync completion
  assign cfg_next = '{
    enable: regs_reg[IDX_CTL_A][CA_EN],
    ctrl_b: regs_reg[IDX_CTL_B][10:0],
    win_mode: regs_reg[IDX_WIN][2:0],
    input_sel: regs_reg[IDX_INPUT][27:0],
    win_lo: regs_reg[IDX_WLO][15:0],
    win_hi: regs_reg[IDX_WHI][15:0]
  };

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  // bus-side registers; soft reset spares debug control
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NREG; i++) regs_reg[i] <= RST_VAL;
    end else if (ce) begin
      if (srst_apply) begin
        for (int i = 0; i < NREG; i++) begin
          if (idx_t'(i) != IDX_DBG) regs_reg[i] <= RST_VAL;
        end
      end else begin
        if (sync_done) regs_reg[IDX_TRIG] <= RST_VAL;
        if (wr_ok && (is_plain(wr_idx) || wr_idx == IDX_CTL_A)) begin
          regs_reg[wr_idx] <= wr_val;
        end
      end
    end
  end

  // synchronizer delay counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_cnt_reg <= 3'h0;
    end else if (ce) begin
      if (sync_start) sync_cnt_reg <= SYNC_CYCLES;
      else if (busy) sync_cnt_reg <= sync_cnt_reg - 3'h1;
    end
  end

  // converter-side copies and trigger pulses
  always_ff @(posedge aclk) begin
    if (!aresetn || (ce && srst_apply)) begin
      conv_cfg_reg <= '0;
      conv_start_reg <= 1'b0;
      conv_flush_reg <= 1'b0;
    end else if (ce) begin
      if (sync_done) conv_cfg_reg <= cfg_next;
      conv_start_reg <= sync_done && regs_reg[IDX_TRIG][SW_START];
      conv_flush_reg <= sync_done && regs_reg[IDX_TRIG][SW_FLUSH];
    end
  end

  // standby gating of the converter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_active_reg <= 1'b0;
    end else if (ce) begin
      conv_active_reg <= conv_cfg_reg.enable && (!standby_sleep ||
                         regs_reg[IDX_CTL_A][CA_RUNSTBY]);
    end
  end

  // ----------------------------------------------------------------
  // interrupts and result
  // ----------------------------------------------------------------
  // sticky flags, enable mask, level interrupt
  always_ff @(posedge aclk) begin
    if (!aresetn || (ce && srst_apply)) begin
      flags_reg <= 4'h0;
      imask_reg <= 4'h0;
      result_reg <= 16'h0000;
      irq_reg <= 1'b0;
    end else if (ce) begin
      flags_reg <= flags_next;
      imask_reg <= (imask_reg & ~ien_clr) | ien_set;
      if (conv_evt.result_ready) result_reg <= conv_evt.result;
      irq_reg <= |(flags_reg & imask_reg);
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  // write channel: address and data taken together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (ce) begin
      awready_reg <= !awready_reg && awvalid && wvalid &&
                     !bvalid_reg && !wstall;
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_resp;
      end else if (bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // read channel: synchronized reads wait for the counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rd_wait_reg <= 1'b0;
      rd_idx_reg <= IDX_CTL_A;
      rdata_reg <= RST_VAL;
      rresp_reg <= RESP_OKAY;
    end else if (ce) begin
      arready_reg <= !arready_reg && arvalid && !rvalid_reg &&
                     !rd_wait_reg && !rstall;
      if (rd_acc) rd_idx_reg <= ar_idx;
      if (rd_acc && is_rsync(ar_idx)) rd_wait_reg <= 1'b1;
      else if (sync_done) rd_wait_reg <= 1'b0;
      if ((rd_acc && !is_rsync(ar_idx)) ||
          (rd_wait_reg && sync_done)) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_word;
        rresp_reg <= (mask_of(sel_idx) == 32'h0000_0000) ?
                     RESP_SLVERR : RESP_OKAY;
      end else if (rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // outputs straight from flip-flops
  assign awready = awready_reg;
  assign wready = awready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign conv_cfg = conv_cfg_reg;
  assign conv_active = conv_active_reg;
  assign conv_start = conv_start_reg;
  assign conv_flush = conv_flush_reg;
  assign irq = irq_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  // busy runs for the full synchronizer delay
  sequence s_sync_run;
    busy [*4] ##1 !busy;
  endsequence

  a_busy_set_on: assert property (
    wr_ok && is_wsync(wr_idx) |=> busy)
    else $error("busy not set by synchronized write");

  a_busy_clears: assert property (
    $rose(busy) |-> s_sync_run)
    else $error("busy length wrong");

  a_enable_readback: assert property (
    wr_ok && wr_idx == IDX_CTL_A && wstrb[0] && !wdata[CA_SRST] &&
    !sync_done |=> regs_reg[IDX_CTL_A][CA_EN] == $past(wdata[CA_EN]))
    else $error("enable bit not read back at once");

  a_enable_late: assert property (
    sync_done && !srst_pend |=>
    conv_cfg_reg.enable == $past(regs_reg[IDX_CTL_A][CA_EN]))
    else $error("converter enable not applied at sync end");

  a_guard_blocks: assert property (
    wr_fire && peripheral_access_guard && wr_idx == IDX_REF &&
    !sync_done |=> $stable(regs_reg[IDX_REF]))
    else $error("guarded register written");

  a_enprot_blocks: assert property (
    wr_fire && conv_on && wr_idx == IDX_REF && !sync_done
    |=> $stable(regs_reg[IDX_REF]))
    else $error("enable-protected register written while on");

  a_byte_lane: assert property (
    wr_ok && wr_idx == IDX_WLO && wstrb == 4'h1 && !sync_done |=>
    regs_reg[IDX_WLO][15:8] == $past(regs_reg[IDX_WLO][15:8]) &&
    regs_reg[IDX_WLO][7:0] == $past(wdata[7:0]))
    else $error("byte write disturbed other lane");

  a_sync_stall: assert property (
    wr_fire && is_wsync(wr_idx) |-> !busy)
    else $error("synchronized write taken while busy");

  a_read_sync: assert property (
    rd_acc && is_rsync(ar_idx) |=> !rvalid_reg [*4] ##1 rvalid_reg)
    else $error("synchronized read timing wrong");

  a_srst_done: assert property (
    srst_apply |=> !srst_pend && !busy && !conv_cfg_reg.enable &&
    regs_reg[IDX_CTL_A] == RST_VAL)
    else $error("soft reset incomplete");

  a_flag_clear: assert property (
    wr_ok && wr_idx == IDX_FLAG && wstrb[0] && wdata[FL_SYNC] &&
    !sync_done |=> !flags_reg[FL_SYNC])
    else $error("flag not cleared by writing one");

  a_standby_halt: assert property (
    standby_sleep && !regs_reg[IDX_CTL_A][CA_RUNSTBY] |=> !conv_active)
    else $error("converter runs in standby");

endmodule

`default_nettype wire

// File: dv/conv_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module conv_core_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // settings and trigger from the register block
  input wire adc_regs_pkg::conv_cfg_t conv_cfg,
  input wire logic conv_active,
  input wire logic conv_start,
  // events back to the register block
  output var adc_regs_pkg::conv_evt_t conv_evt
);
  import adc_regs_pkg::*;
  logic [1:0] busy_reg;
  logic [15:0] last_reg;

  // ----------------------------------------------------------------
  // conversion timing
  // ----------------------------------------------------------------
  // a start seen while active reports a result three cycles later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_reg <= 2'h0;
    end else if (conv_start && conv_active) begin
      busy_reg <= 2'h3;
    end else if (busy_reg != 2'h0) begin
      busy_reg <= busy_reg - 2'h1;
    end
  end

  // remembers the result so the idle bus can show its inverse
  always_ff @(posedge aclk) begin
    if (conv_evt.result_ready) begin
      last_reg <= conv_evt.result;
    end
  end

  // result bus is only meaningful with result_ready
  always_comb begin
    conv_evt = '0;
    conv_evt.result_ready = (busy_reg == 2'h1);
    conv_evt.result = conv_evt.result_ready ? conv_cfg.input_sel[15:0] :
                      ~last_reg;
  end
endmodule

`default_nettype wire

// File: dv/adc_register_interface_bench.sv
`timescale 1ns/1ps
`default_nettype none

module adc_register_interface_bench;
  import adc_regs_pkg::*;
  logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq, guard, sleep;
  logic conv_active, conv_start, conv_flush;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rnd, exp;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  conv_evt_t conv_evt;
  conv_cfg_t conv_cfg;
  logic [1:0] wq[$];
  logic [33:0] rq[$];
  int errors, comparisons;

  // ----------------------------------------------------------------
  // design and converter model
  // ----------------------------------------------------------------
  adc_register_interface u_adc_register_interface (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .peripheral_access_guard(guard), .standby_sleep(sleep),
    .conv_evt(conv_evt), .conv_cfg(conv_cfg), .conv_active(conv_active),
    .conv_start(conv_start), .conv_flush(conv_flush), .irq(irq));

  conv_core_model u_conv_core_model (
    .aclk(aclk), .aresetn(aresetn), .conv_cfg(conv_cfg),
    .conv_active(conv_active), .conv_start(conv_start),
    .conv_evt(conv_evt));

  // ----------------------------------------------------------------
  // checking and reporting
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task report_and_stop;
    if (errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task judge(input logic [33:0] e, input logic [33:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task cmp_resp(input logic [1:0] e, input logic [1:0] g);
    judge({32'h0, e}, {32'h0, g});
  endtask

  task cmp_read(input logic [33:0] e, input logic [33:0] g);
    judge(e, g);
  endtask

  task cmp_val(input logic [31:0] e, input logic [31:0] g);
    judge({2'h0, e}, {2'h0, g});
  endtask

  // takes the oldest note whenever a response is handed over
  always @(posedge aclk) begin
    if (bvalid === 1'b1 && bready === 1'b1)
      cmp_resp(wq.pop_front(), bresp);
    if (rvalid === 1'b1 && rready === 1'b1)
      cmp_read(rq.pop_front(), {rresp, rdata});
  end

  // ----------------------------------------------------------------
  // bus master tasks
  // ----------------------------------------------------------------
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
          input logic [1:0] e);
    int n;
    n = 0;
    wq.push_back(e);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin @(posedge aclk); n++; end while (awready !== 1'b1 && n < 60);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do begin @(posedge aclk); n++; end while (bvalid !== 1'b1 && n < 60);
    bready <= 1'b0;
    if (n >= 60) errors++;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    n = 0;
    rq.push_back({e, d});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin @(posedge aclk); n++; end while (arready !== 1'b1 && n < 60);
    arvalid <= 1'b0;
    do begin @(posedge aclk); n++; end while (rvalid !== 1'b1 && n < 60);
    rready <= 1'b0;
    if (n >= 60) errors++;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // whole sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    report_and_stop;
  end

  initial begin
    errors = 0;
    comparisons = 0;
    rnd = 32'h2639;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {guard, sleep, awaddr, araddr, wdata, wstrb} = '0;
    ce = 1'b1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, 32'h0, RESP_OKAY);
    rd(8'h60, 32'h0, RESP_OKAY);
    // byte and halfword lanes, stalled synced writes
    wr(8'h04, 32'h0000_008F, 4'h1, RESP_OKAY);
    rd(8'h04, 32'h0000_008F, RESP_OKAY);
    wr(8'h10, 32'h0000_0700, 4'h2, RESP_OKAY);
    wr(8'h10, 32'hFFFF_FF37, 4'h1, RESP_OKAY);
    rd(8'h10, 32'h0000_0737, RESP_OKAY);
    wr(8'h70, 32'h0000_1234, 4'h3, RESP_OKAY);
    wr(8'h70, 32'h0000_00AB, 4'h1, RESP_OKAY);
    rd(8'h70, 32'h0000_12AB, RESP_OKAY);
    rnd = lfsr(rnd);
    wr(8'h40, rnd, 4'hF, RESP_OKAY);
    wr(8'h40, 32'hA5A5_A5A5, 4'h4, RESP_OKAY);
    exp = ((rnd & 32'hFF00_FFFF) | 32'h00A5_0000) & MSK_INPUT;
    rd(8'h40, exp, RESP_OKAY);
    cmp_val(exp, {4'h0, conv_cfg.input_sel});
    // access guard
    guard <= 1'b1;
    wr(8'h04, 32'h0000_0001, 4'h1, RESP_SLVERR);
    wr(8'h5C, 32'h0000_0000, 4'h1, RESP_OKAY);
    guard <= 1'b0;
    rd(8'h04, 32'h0000_008F, RESP_OKAY);
    // enable with run in standby
    wr(8'h00, 32'h0000_0006, 4'h1, RESP_OKAY);
    cmp_val(32'h0, conv_cfg.enable);
    rd(8'h00, 32'h0000_0006, RESP_OKAY);
    repeat (8) @(posedge aclk);
    cmp_val(32'h1, conv_cfg.enable);
    sleep <= 1'b1;
    repeat (3) @(posedge aclk);
    cmp_val(32'h1, conv_active);
    rd(8'h64, 32'h0, RESP_OKAY);
    rd(8'h60, 32'h0000_0008, RESP_OKAY);
    wr(8'h04, 32'h0000_0001, 4'h1, RESP_OKAY);
    rd(8'h04, 32'h0000_008F, RESP_OKAY);
    wr(8'h00, 32'h0000_0002, 4'h1, RESP_OKAY);
    repeat (8) @(posedge aclk);
    cmp_val(32'h0, conv_active);
    sleep <= 1'b0;
    repeat (3) @(posedge aclk);
    cmp_val(32'h1, conv_active);
    // interrupt flags and mask
    wr(8'h5C, 32'h0000_0009, 4'h1, RESP_OKAY);
    repeat (2) @(posedge aclk);
    cmp_val(32'h1, irq);
    wr(8'h60, 32'h0000_0000, 4'h1, RESP_OKAY);
    rd(8'h60, 32'h0000_0008, RESP_OKAY);
    wr(8'h60, 32'h0000_0008, 4'h1, RESP_OKAY);
    repeat (2) @(posedge aclk);
    cmp_val(32'h0, irq);
    wr(8'h30, 32'h0000_0002, 4'h1, RESP_OKAY);
    repeat (12) @(posedge aclk);
    rd(8'h68, {16'h0, exp[15:0]}, RESP_OKAY);
    rd(8'h60, 32'h0000_0009, RESP_OKAY);
    cmp_val(32'h1, irq);
    wr(8'h58, 32'h0000_0009, 4'h1, RESP_OKAY);
    repeat (2) @(posedge aclk);
    cmp_val(32'h0, irq);
    rd(8'h5C, 32'h0, RESP_OKAY);
    // soft reset wins over enable, keeps debug control
    wr(8'hA8, 32'h0000_0001, 4'h1, RESP_OKAY);
    wr(8'h00, 32'h0000_0003, 4'h1, RESP_OKAY);
    repeat (8) @(posedge aclk);
    rd(8'h00, 32'h0, RESP_OKAY);
    rd(8'h04, 32'h0, RESP_OKAY);
    rd(8'hA8, 32'h0000_0001, RESP_OKAY);
    cmp_val(32'h0, conv_cfg.enable);
    wr(8'h14, 32'h0000_0001, 4'hF, RESP_SLVERR);
    report_and_stop;
  end
endmodule

`default_nettype wire
